/* File: rtl/lnb_regs.svh */
// Overview of operation
// - external select takes keying waveform as tone
// - tone follows key frequency and duty
// - host sets select and enable first
// - external mode: start 1us, stop 60us
// - envelope mode: tone while key high
// - envelope: start 6us, stop 15-60us
// - low loss bit only without tone
// - host clears low loss before tone
// - host sets enable before, clears after
// - bypass drive asserted during tone
// - sense tone demodulated to detect output
// - four bit voltage field in data one
// - eight diagnostic bits, zero when healthy
// - overload overheat supply flags latch until read
// - fault pin low while latched flag set
// - vout low flag follows monitor while enabled
// - tone present flag set on detection
// - continuous tone: key high, select zero
// Purpose: register offsets, fields and timing for the tone and fault block
// Assumes: 40 MHz clock
// Notes: offsets are word byte addresses
`ifndef LNB_REGS_SVH
`define LNB_REGS_SVH
`define LNB_CLK_MHZ 40
`define LNB_ADR_DATA1 4'h0
`define LNB_ADR_CTRL 4'h4
`define LNB_ADR_STAT1 4'h8
`define LNB_ADR_STAT2 4'hC
`define LNB_CTRL_TONE_ON 0
`define LNB_CTRL_EXT 1
`define LNB_CTRL_LOWLOSS 2
`define LNB_EXT_START_US 1
`define LNB_EXT_STOP_US 60
`define LNB_ENV_START_US 6
`define LNB_ENV_STOP_US 30
`define LNB_DET_HOLD_US 60
`define LNB_HALF_PERIOD_NS 22727
`define LNB_WB_DEV 4'h2
`define LNB_WB_KEY 8'h10
`define LNB_WB_IRQ 8'h14
`define LNB_WB_MASK 8'h18
`endif

/* File: rtl/lnb_pkg.sv */
// Purpose: shared types
// Assumes: nothing
// Notes: none
package lnb_pkg;
    typedef enum logic [1:0] {LNB_IDLE, LNB_START, LNB_ON, LNB_STOP} lnb_tone_e;
endpackage

/* File: rtl/lnb_if.sv */
// Purpose: pins between regulator logic and host
// Assumes: fault pin open drain, resolved by bench
// Notes: register access is a simple strobe bus on the pins
`timescale 1ns/1ps
`default_nettype none
interface lnb_if;
    logic tone_key_in;
    logic tone_detect_out;
    logic filter_bypass_drive;
    logic fault_n_out_o;
    logic fault_n_out_oe_n;
    logic reg_wr;
    logic reg_rd;
    logic [3:0] reg_adr;
    logic [7:0] reg_wdat;
    logic [7:0] reg_rdat;
    modport dev (input tone_key_in, reg_wr, reg_rd, reg_adr, reg_wdat,
        output tone_detect_out, filter_bypass_drive, fault_n_out_o, fault_n_out_oe_n, reg_rdat);
    modport host (output tone_key_in, reg_wr, reg_rd, reg_adr, reg_wdat,
        input tone_detect_out, filter_bypass_drive, fault_n_out_o, fault_n_out_oe_n, reg_rdat);
endinterface
`default_nettype wire

/* File: rtl/lnb_dev.sv */
// Purpose: tone gating, filter bypass, tone detect and latched diagnostics
// Assumes: analog monitors arrive as asynchronous levels
// Notes: status reads clear latched flags whose cause is gone
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`include "lnb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module lnb_dev #(
    parameter int EXT_START = `LNB_EXT_START_US * `LNB_CLK_MHZ,
    parameter int EXT_STOP = `LNB_EXT_STOP_US * `LNB_CLK_MHZ,
    parameter int ENV_START = `LNB_ENV_START_US * `LNB_CLK_MHZ,
    parameter int ENV_STOP = `LNB_ENV_STOP_US * `LNB_CLK_MHZ,
    parameter int DET_HOLD = `LNB_DET_HOLD_US * `LNB_CLK_MHZ,
    parameter int HALF = (`LNB_HALF_PERIOD_NS * `LNB_CLK_MHZ) / 1000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    lnb_if.dev pins,
    input wire logic [5:0] mon_i,
    input wire logic tone_sense_in_i,
    output logic tone_o,
    output logic [3:0] vsel_o,
    output logic low_loss_sel_o
);
    // mon_i: 0 overload,1 overheat,2 supply low,3 vout low,4 tone fault,5 min load
    logic [5:0] m1_q, m2_q;
    logic k1_q, k2_q, s1_q, s2_q, kp_q, sp_q;
    logic [3:0] vsel_q;
    logic [2:0] ctrl_q;
    logic [2:0] latch_q;
    logic sink_q;
    logic present_q, det_q;
    logic [15:0] cnt_q, hc_q, dc_q;
    logic gen_q, tone_q;
    logic [7:0] rdat_q;
    lnb_pkg::lnb_tone_e st_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {m1_q, m2_q, k1_q, k2_q, s1_q, s2_q} <= '0;
        end else begin
            m1_q <= mon_i;
            m2_q <= m1_q;
            k1_q <= pins.tone_key_in;
            k2_q <= k1_q;
            s1_q <= tone_sense_in_i;
            s2_q <= s1_q;
        end
    end
    wire tone_on = ctrl_q[`LNB_CTRL_TONE_ON];
    wire ext = ctrl_q[`LNB_CTRL_EXT];
    wire key_edge = k2_q != kp_q;
    // envelope: level high; external: any edge keeps activity alive
    wire active = tone_on && (ext ? key_edge : k2_q);
    wire [15:0] start_n = ext ? 16'(EXT_START) : 16'(ENV_START);
    wire [15:0] stop_n = ext ? 16'(EXT_STOP) : 16'(ENV_STOP);
    wire vout_en = vsel_q != 4'h0;
    wire stat_rd = pins.reg_rd && (pins.reg_adr == `LNB_ADR_STAT1 ||
        pins.reg_adr == `LNB_ADR_STAT2);
    wire [2:0] cause = m2_q[2:0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= lnb_pkg::LNB_IDLE;
            cnt_q <= '0;
            kp_q <= 1'b0;
        end else begin
            kp_q <= k2_q;
            unique case (st_q)
                lnb_pkg::LNB_IDLE: if (active) begin
                    st_q <= lnb_pkg::LNB_START;
                    cnt_q <= '0;
                end
                lnb_pkg::LNB_START: if (!(tone_on && (ext || k2_q))) begin
                    st_q <= lnb_pkg::LNB_IDLE;
                end else if (cnt_q + 16'h1 >= start_n) begin
                    st_q <= lnb_pkg::LNB_ON;
                    cnt_q <= '0;
                end else begin
                    cnt_q <= cnt_q + 16'h1;
                end
                lnb_pkg::LNB_ON, lnb_pkg::LNB_STOP: if (active) begin
                    st_q <= lnb_pkg::LNB_ON;
                    cnt_q <= '0;
                end else if (cnt_q + 16'h1 >= stop_n) begin
                    st_q <= lnb_pkg::LNB_IDLE;
                end else begin
                    st_q <= lnb_pkg::LNB_STOP;
                    cnt_q <= cnt_q + 16'h1;
                end
            endcase
        end
    end
    // internal 22 kHz generator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hc_q <= '0;
            gen_q <= 1'b0;
            tone_q <= 1'b0;
        end else begin
            if (hc_q + 16'h1 >= 16'(HALF)) begin
                hc_q <= '0;
                gen_q <= ~gen_q;
            end else begin
                hc_q <= hc_q + 16'h1;
            end
            // external mode: shape follows key, level and edges set here
            tone_q <= (st_q != lnb_pkg::LNB_IDLE && st_q != lnb_pkg::LNB_START) &&
                (ext ? k2_q : gen_q);
        end
    end
    // detector: sense edges retrigger a hold window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_q <= 1'b0;
            dc_q <= '0;
            det_q <= 1'b0;
            present_q <= 1'b0;
        end else begin
            sp_q <= s2_q;
            if (s2_q != sp_q) begin
                dc_q <= 16'(DET_HOLD);
                det_q <= 1'b1;
            end else if (dc_q != 16'h0) begin
                dc_q <= dc_q - 16'h1;
            end else begin
                det_q <= 1'b0;
            end
            if (det_q) begin
                present_q <= 1'b1;
            end else if (stat_rd) begin
                present_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vsel_q <= '0;
            ctrl_q <= '0;
            latch_q <= '0;
            sink_q <= 1'b0;
        end else begin
            if (pins.reg_wr && pins.reg_adr == `LNB_ADR_DATA1) begin
                vsel_q <= pins.reg_wdat[3:0];
            end
            if (pins.reg_wr && pins.reg_adr == `LNB_ADR_CTRL) begin
                ctrl_q <= pins.reg_wdat[2:0];
            end
            // set wins; read clears only once cause is gone
            latch_q <= cause | (stat_rd ? 3'b000 : latch_q);
            sink_q <= m2_q[5] & vout_en;
        end
    end
    // status1: 0 ovl,1 ovh,2 supply,3 vout low; status2: 0 tone fault,1 min load,2 sink,3 present
    wire [7:0] stat1 = {4'h0, vout_en & m2_q[3], latch_q};
    wire [7:0] stat2 = {4'h0, present_q, sink_q, m2_q[5], m2_q[4]};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= '0;
        end else if (pins.reg_rd) begin
            unique case (pins.reg_adr)
                `LNB_ADR_DATA1: rdat_q <= {4'h0, vsel_q};
                `LNB_ADR_CTRL: rdat_q <= {5'h00, ctrl_q};
                `LNB_ADR_STAT1: rdat_q <= stat1;
                `LNB_ADR_STAT2: rdat_q <= stat2;
                default: rdat_q <= 8'h00;
            endcase
        end
    end
    assign pins.reg_rdat = rdat_q;
    assign pins.fault_n_out_o = 1'b0;
    assign pins.fault_n_out_oe_n = ~(|latch_q);
    assign pins.filter_bypass_drive = st_q == lnb_pkg::LNB_ON || st_q == lnb_pkg::LNB_STOP;
    assign pins.tone_detect_out = det_q;
    assign tone_o = tone_q;
    assign vsel_o = vsel_q;
    assign low_loss_sel_o = ctrl_q[`LNB_CTRL_LOWLOSS];
endmodule
`default_nettype wire

/* File: rtl/lnb_host.sv */
// Purpose: host end: Wishbone slave driving the keying and register pins
// Assumes: device answers reads one cycle after strobe
// Notes: wishbone 0x20 pass addr, 0x10 command, 0x14 status/irq, 0x18 mask
`include "lnb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module lnb_host (
    input wire logic clk_i,
    input wire logic rst_i,
    lnb_if.host pins,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);
    logic f1_q, f2_q, fp_q;
    logic [3:0] padr_q;
    logic key_q, wr_q, rd_q, ack_q, busy_q, rdw_q;
    logic [7:0] wdat_q;
    logic [31:0] dat_q;
    logic [1:0] irq_st_q, irq_mask_q;
    wire req = wb_cyc_i && wb_stb_i && !ack_q;
    wire a_data = wb_adr_i[7:4] == `LNB_WB_DEV;
    wire a_key = wb_adr_i == `LNB_WB_KEY;
    wire a_st = wb_adr_i == `LNB_WB_IRQ;
    wire a_mk = wb_adr_i == `LNB_WB_MASK;
    wire fault_ev = !f2_q && fp_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {f1_q, f2_q, fp_q} <= 3'b111;
            {key_q, wr_q, rd_q, ack_q, busy_q, rdw_q} <= '0;
            padr_q <= '0;
            wdat_q <= '0;
            dat_q <= '0;
            irq_st_q <= '0;
            irq_mask_q <= '0;
        end else begin
            f1_q <= pins.fault_n_out_oe_n;
            f2_q <= f1_q;
            fp_q <= f2_q;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            irq_st_q <= irq_st_q | {1'b0, fault_ev};
            if (busy_q) begin
                // device registers its read data on this edge
                busy_q <= 1'b0;
                rdw_q <= 1'b1;
            end else if (rdw_q) begin
                rdw_q <= 1'b0;
                ack_q <= 1'b1;
                dat_q <= {24'h0, pins.reg_rdat};
            end else if (req) begin
                if (a_data) begin
                    // 0x20+4n: device register n*4
                    wr_q <= wb_we_i;
                    rd_q <= !wb_we_i;
                    padr_q <= {wb_adr_i[3:2], 2'b00};
                    wdat_q <= wb_dat_i[7:0];
                    busy_q <= !wb_we_i;
                    ack_q <= wb_we_i;
                end else begin
                    ack_q <= 1'b1;
                    dat_q <= a_key ? {31'h0, key_q} :
                        a_st ? {30'h0, irq_st_q} :
                        a_mk ? {30'h0, irq_mask_q} : 32'h0;
                    if (wb_we_i && a_key) begin
                        key_q <= wb_dat_i[0];
                    end
                    if (wb_we_i && a_st) begin
                        irq_st_q <= (irq_st_q & ~wb_dat_i[1:0]) | {1'b0, fault_ev};
                    end
                    if (wb_we_i && a_mk) begin
                        irq_mask_q <= wb_dat_i[1:0];
                    end
                end
            end
        end
    end
    assign pins.tone_key_in = key_q;
    assign pins.reg_wr = wr_q;
    assign pins.reg_rd = rd_q;
    assign pins.reg_adr = padr_q;
    assign pins.reg_wdat = wdat_q;
    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign irq_o = |(irq_st_q & ~irq_mask_q);
endmodule
`default_nettype wire

/* File: sim/lnb_checker.sv */
// Purpose: concurrent checks on the pins between host end and device end
// Assumes: one clock, synchronous active-high reset
// Notes: stop bounds take the shorter and the longer stop count
`timescale 1ns/1ps
`default_nettype none
module lnb_checker #(
    parameter int STOP_MIN = 20,
    parameter int STOP_MAX = 40
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tone_key_in,
    input wire logic filter_bypass_drive,
    input wire logic fault_n_out_o,
    input wire logic fault_n_out_oe_n,
    input wire logic reg_wr,
    input wire logic reg_rd
);
    logic [7:0] low_q;
    logic [7:0] low_d;
    // cycles the key has been low, saturating
    assign low_d = tone_key_in ? 8'h00 : (low_q == 8'hFF ? low_q : low_q + 8'h01);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_d;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    fault_level_a: assert property (fault_n_out_o == 1'b0)
        else $error("fault pin drives high");
    fault_release_a: assert property ($rose(fault_n_out_oe_n) |->
        $past(reg_rd) || $past(reg_rd, 2) || $past(reg_rd, 3) || $past(reg_rd, 4))
        else $error("fault pin freed without a read");
    wr_pulse_a: assert property (reg_wr |=> !reg_wr)
        else $error("write strobe longer than a cycle");
    rd_pulse_a: assert property (reg_rd |=> !reg_rd)
        else $error("read strobe longer than a cycle");
    bypass_start_a: assert property ($rose(filter_bypass_drive) |-> $past(tone_key_in, 2))
        else $error("bypass before synchronised key");
    bypass_stop_a: assert property ($fell(filter_bypass_drive) |-> low_q >= STOP_MIN)
        else $error("bypass dropped too early");
    bypass_end_a: assert property (low_q == STOP_MAX + 8 |-> !filter_bypass_drive)
        else $error("bypass still high after stop");
    bypass_min_a: assert property ($rose(filter_bypass_drive) |-> filter_bypass_drive[*8])
        else $error("bypass pulse too short");
endmodule
`default_nettype wire

/* File: sim/lnb_tone_gating_and_fault_flags_tb.sv */
// Purpose: bench for host and device ends joined by their pin interface
// Assumes: shortened timing counts, one 40 MHz clock
// Notes: tone sense driven by a short burst
`timescale 1ns/1ps
`default_nettype none
module lnb_tone_gating_and_fault_flags_tb;
    localparam int ES = 4, XS = 40, NS = 8, NP = 20;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [3:0] v; logic l;} lnb_row_s;
    lnb_row_s rows [5] = '{'{8'h20, 8'h0F, 4'hF, 1'b0}, '{8'h24, 8'h04, 4'hF, 1'b1},
        '{8'h20, 8'h00, 4'h0, 1'b1}, '{8'h24, 8'h00, 4'h0, 1'b0}, '{8'h20, 8'h05, 4'h5, 1'b0}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [5:0] mon = 6'h00;
    logic sense = 1'b0;
    logic [31:0] rd;
    logic ack, irq, tone, ll;
    logic [3:0] vsel;
    int error_cnt = 0;
    int checks = 0;
    int rises = 0;
    int n;
    lnb_if lnb_if_inst();
    wire logic byp = lnb_if_inst.filter_bypass_drive;
    wire logic fault_pin = lnb_if_inst.fault_n_out_oe_n ? 1'b1 : lnb_if_inst.fault_n_out_o;
    lnb_dev #(.EXT_START(ES), .EXT_STOP(XS), .ENV_START(NS), .ENV_STOP(NP), .DET_HOLD(40),
        .HALF(4))
        lnb_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .pins(lnb_if_inst.dev), .mon_i(mon),
        .tone_sense_in_i(sense), .tone_o(tone), .vsel_o(vsel), .low_loss_sel_o(ll));
    lnb_host lnb_host_inst (.clk_i(clk_i), .rst_i(rst_i), .pins(lnb_if_inst.host),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .irq_o(irq));
    lnb_checker #(.STOP_MIN(NP), .STOP_MAX(XS)) lnb_checker_inst (.clk_i(clk_i),
        .rst_i(rst_i), .tone_key_in(lnb_if_inst.tone_key_in), .filter_bypass_drive(byp),
        .fault_n_out_o(lnb_if_inst.fault_n_out_o),
        .fault_n_out_oe_n(lnb_if_inst.fault_n_out_oe_n),
        .reg_wr(lnb_if_inst.reg_wr), .reg_rd(lnb_if_inst.reg_rd));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge tone) rises++;
    task automatic test_done();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic chk_n(input int v, input int lo, input int hi, input string m);
        checks++;
        if (v < lo || v > hi) begin
            error_cnt++;
            $display("wrong value at %0t: %s took %0d cycles", $time, m, v);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 40);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (k >= 40) chk(1'b0, 1'b1, "no ack");
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e, m);
    endtask
    task automatic meas(input logic s, input logic v, output int c);
        c = 0;
        while ((s ? byp : tone) !== v && c < 200) begin
            @(posedge clk_i);
            c++;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        chk({vsel, ll, tone, fault_pin, irq}, 8'h02, "reset");
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk(8'h28, 32'h0, "status1 idle");
        rdchk(8'h2C, 32'h0, "status2 idle");
        rdchk(8'h40, 32'h0, "unmapped");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk({vsel, ll}, {rows[i].v, rows[i].l}, "row");
        end
        wr(8'h10, 8'h01);
        repeat (3 * NS) @(posedge clk_i);
        chk({tone, byp}, 2'b00, "tone off");
        wr(8'h10, 8'h00);
        wr(8'h24, 8'h01);
        wr(8'h10, 8'h01);
        meas(1'b1, 1'b1, n);
        chk_n(n, NS - 2, NS + 4, "env start");
        rises = 0;
        repeat (20) @(posedge clk_i);
        chk(byp, 1'b1, "env on");
        chk_n(rises, 2, 3, "env tone");
        wr(8'h10, 8'h00);
        meas(1'b1, 1'b0, n);
        chk_n(n, NP - 2, NP + 5, "env stop");
        @(posedge clk_i);
        chk(tone, 1'b0, "env off");
        wr(8'h24, 8'h03);
        wr(8'h10, 8'h01);
        meas(1'b0, 1'b1, n);
        chk_n(n, ES - 2, ES + 4, "ext start");
        rises = 0;
        repeat (4) begin
            wr(8'h10, 8'h00);
            repeat (6) @(posedge clk_i);
            wr(8'h10, 8'h01);
            repeat (6) @(posedge clk_i);
        end
        chk(rises, 4, "ext pulses");
        wr(8'h10, 8'h00);
        meas(1'b1, 1'b0, n);
        chk_n(n, XS - 2, XS + 5, "ext stop");
        wr(8'h24, 8'h00);
        for (int b = 0; b < 4; b++) begin
            mon[b] <= 1'b1;
            repeat (8) @(posedge clk_i);
            chk({fault_pin, irq}, {b == 3, b < 3}, "fault on");
            rdchk(8'h28, 8'h01 << b, "flag set");
            if (b == 0) begin
                wr(8'h18, 8'h01);
                chk(irq, 1'b0, "masked");
                wr(8'h18, 8'h00);
                chk(irq, 1'b1, "unmasked");
            end
            mon[b] <= 1'b0;
            repeat (6) @(posedge clk_i);
            rdchk(8'h28, b < 3 ? 8'h01 << b : 8'h00, "flag held");
            rdchk(8'h28, 32'h0, "flag clear");
            repeat (4) @(posedge clk_i);
            wr(8'h14, 8'h01);
            chk({fault_pin, irq}, 2'b10, "fault off");
        end
        sense <= 1'b1;
        repeat (4) @(posedge clk_i);
        sense <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(lnb_if_inst.tone_detect_out, 1'b1, "detect");
        rdchk(8'h2C, 32'h08, "present");
        mon[1] <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b1;
        mon <= 6'h00;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({vsel, fault_pin, irq}, 6'h02, "rerun reset");
        test_done();
    end
endmodule
`default_nettype wire
